// [nine_bit_async_serial_port.v]
// Nine-bit asynchronous serial port (modes 2 and 3) with AXI4-Lite registers
// Functional notes
// - Eleven-bit frame: start, eight data LSB-first, ninth, stop
// - Transmitted ninth bit comes from tx_ninth_bit
// - Mode 2 bit rate clk/64, or clk/32 doubled
// - Transmit starts at next divide-by-16 rollover
// - Transmit order: start, data LSB-first, ninth, stop
// - Transmit flag sets when stop bit is driven
// - Receiver starts on falling edge when enabled
// - Sixteen samples per bit, counter reset on edge
// - Bit value is majority of three mid-bit samples
// - Start not confirmed low: abandon, await edge
// - Accept needs flag clear, stop high in multiprocessor
// - Accept loads byte, ninth bit, sets receive flag
// - Rejected frame leaves buffer and flags unchanged
// - After mid stop bit, return idle awaiting edge
// - Mode 3: mode 2 frame, timer-overflow bit rate
// - Multiprocessor: interrupt only when ninth bit is one
// - Timer 1 overflow /32 or /16, timer 2 /16
// - Double-rate flag is power control bit seven
`timescale 1ns/1ps
`include "serial_port_defs.vh"
module nine_bit_async_serial_port #(
  parameter ADDR_W = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              timer1_overflow,
  input  wire              timer2_overflow,
  input  wire              rxd,
  output reg               txd,
  output wire              serial_irq
);
  localparam RX_IDLE  = 4'h1;
  localparam RX_START = 4'h2;
  localparam RX_DATA  = 4'h4;
  localparam RX_STOP  = 4'h8;

  // Software-visible state
  reg        rx_complete_flag;
  reg        tx_complete_flag;
  reg        rx_ninth_bit;
  reg        tx_ninth_bit;
  reg        rx_enable;
  reg        multiproc_enable;
  reg        mode3_select;
  reg        double_rate;
  reg        tx_rate_from_timer_two;
  reg        rx_rate_from_timer_two;
  reg [7:0]  rx_data_buf;

  // AXI write channel holding registers
  reg              aw_held;
  reg              w_held;
  reg [ADDR_W-1:0] wr_addr;
  reg [7:0]        wr_byte;
  reg              wr_lane0;

  // Transmitter
  reg [7:0] tx_data_buf;
  reg       tx_pending;
  reg [9:0] tx_shift;
  reg [3:0] tx_left;

  // Receiver
  reg [3:0] rx_state;
  reg [3:0] rx_phase;
  reg [3:0] rx_bits;
  reg [8:0] rx_shift;
  reg       rx_last;
  reg       rx_accept;

  wire m2_tick;
  wire t1_tick;
  wire tx_os;
  wire rx_os;
  wire tx_bit_tick;
  wire rx_vote;
  wire rx_sample;
  wire wr_fire;
  wire wr_hit_ctl;
  wire wr_hit_data;
  wire wr_hit_pwr;
  wire wr_hit_rate;
  wire wr_mapped;
  wire start_edge;
  wire accept_ok;

  // Oversample rates: mode 2 from the core clock, mode 3 from timer overflow
  pulse_divider #(.WIDTH(3)) mode2_prescale (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (1'b0),
    .step    (1'b1),
    .div     (double_rate ? `M2_PRE_FAST : `M2_PRE_SLOW),
    .tick    (m2_tick)
  );

  pulse_divider #(.WIDTH(3)) timer1_prescale (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (1'b0),
    .step    (timer1_overflow),
    .div     (double_rate ? `T1_PRE_FAST : `T1_PRE_SLOW),
    .tick    (t1_tick)
  );

  // Timer 2 overflow already runs at sixteen times the bit rate
  assign tx_os = mode3_select ? (tx_rate_from_timer_two ? timer2_overflow : t1_tick)
                              : m2_tick;
  assign rx_os = mode3_select ? (rx_rate_from_timer_two ? timer2_overflow : t1_tick)
                              : m2_tick;

  // Free-running divide-by-16 sets the transmit bit boundaries
  pulse_divider #(.WIDTH(5)) tx_bit_divider (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (1'b0),
    .step    (tx_os),
    .div     (`OVERSAMPLE),
    .tick    (tx_bit_tick)
  );

  assign rx_sample = rx_os && (rx_state != RX_IDLE) &&
                     (rx_phase >= `PH_SAMPLE_FIRST) && (rx_phase <= `PH_SAMPLE_LAST);

  majority_voter rx_voter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sample  (rx_sample),
    .din     (rxd),
    .vote    (rx_vote)
  );

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit_ctl    = wr_fire && wr_lane0 && (wr_addr == `OFS_SERIAL_CONTROL);
  assign wr_hit_data   = wr_fire && wr_lane0 && (wr_addr == `OFS_SERIAL_DATA);
  assign wr_hit_pwr    = wr_fire && wr_lane0 && (wr_addr == `OFS_POWER_CONTROL);
  assign wr_hit_rate   = wr_fire && wr_lane0 && (wr_addr == `OFS_RATE_SELECT);
  assign wr_mapped     = (wr_addr == `OFS_SERIAL_CONTROL) || (wr_addr == `OFS_SERIAL_DATA) ||
                         (wr_addr == `OFS_POWER_CONTROL) || (wr_addr == `OFS_RATE_SELECT);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      wr_addr      <= {ADDR_W{1'b0}};
      wr_byte      <= 8'h00;
      wr_lane0     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held   <= 1'b1;
        wr_byte  <= s_axi_wdata[7:0];
        wr_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      case (s_axi_araddr)
        `OFS_SERIAL_CONTROL: begin
          s_axi_rdata[`CTL_RX_COMPLETE] <= rx_complete_flag;
          s_axi_rdata[`CTL_TX_COMPLETE] <= tx_complete_flag;
          s_axi_rdata[`CTL_RX_NINTH]    <= rx_ninth_bit;
          s_axi_rdata[`CTL_TX_NINTH]    <= tx_ninth_bit;
          s_axi_rdata[`CTL_RX_ENABLE]   <= rx_enable;
          s_axi_rdata[`CTL_MULTIPROC]   <= multiproc_enable;
          s_axi_rdata[`CTL_MODE3]       <= mode3_select;
        end
        `OFS_SERIAL_DATA: begin
          s_axi_rdata[7:0] <= rx_data_buf;
        end
        `OFS_POWER_CONTROL: begin
          s_axi_rdata[`PWR_DOUBLE_RATE] <= double_rate;
        end
        `OFS_RATE_SELECT: begin
          s_axi_rdata[`RATE_TX_TIMER_TWO] <= tx_rate_from_timer_two;
          s_axi_rdata[`RATE_RX_TIMER_TWO] <= rx_rate_from_timer_two;
        end
        default: begin
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_complete_flag       <= 1'b0;
      tx_complete_flag       <= 1'b0;
      rx_ninth_bit           <= 1'b0;
      tx_ninth_bit           <= 1'b0;
      rx_enable              <= 1'b0;
      multiproc_enable       <= 1'b0;
      mode3_select           <= 1'b0;
      double_rate            <= 1'b0;
      tx_rate_from_timer_two <= 1'b0;
      rx_rate_from_timer_two <= 1'b0;
      rx_data_buf            <= 8'h00;
    end else begin
      if (wr_hit_ctl) begin
        rx_complete_flag <= wr_byte[`CTL_RX_COMPLETE];
        tx_complete_flag <= wr_byte[`CTL_TX_COMPLETE];
        rx_ninth_bit     <= wr_byte[`CTL_RX_NINTH];
        tx_ninth_bit     <= wr_byte[`CTL_TX_NINTH];
        rx_enable        <= wr_byte[`CTL_RX_ENABLE];
        multiproc_enable <= wr_byte[`CTL_MULTIPROC];
        mode3_select     <= wr_byte[`CTL_MODE3];
      end
      if (wr_hit_pwr) begin
        double_rate <= wr_byte[`PWR_DOUBLE_RATE];
      end
      if (wr_hit_rate) begin
        tx_rate_from_timer_two <= wr_byte[`RATE_TX_TIMER_TWO];
        rx_rate_from_timer_two <= wr_byte[`RATE_RX_TIMER_TWO];
      end
      if (tx_bit_tick && (tx_left == 4'h1)) begin
        tx_complete_flag <= 1'b1;
      end
      if (rx_accept) begin
        rx_data_buf      <= rx_shift[7:0];
        rx_ninth_bit     <= rx_shift[8];
        rx_complete_flag <= 1'b1;
      end
    end
  end

  // Both flags stay up until software clears them
  assign serial_irq = rx_complete_flag | tx_complete_flag;

  // A write while a frame is in flight is queued and sent after the stop bit
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_data_buf <= 8'h00;
      tx_pending  <= 1'b0;
      tx_shift    <= 10'h3FF;
      tx_left     <= 4'h0;
      txd         <= 1'b1;
    end else begin
      if (wr_hit_data) begin
        tx_data_buf <= wr_byte;
        tx_pending  <= 1'b1;
      end
      if (tx_bit_tick) begin
        if (tx_left != 4'h0) begin
          txd      <= tx_shift[0];
          tx_shift <= {1'b1, tx_shift[9:1]};
          tx_left  <= tx_left - 4'h1;
        end else if (tx_pending && !wr_hit_data) begin
          txd        <= 1'b0;
          tx_shift   <= {1'b1, tx_ninth_bit, tx_data_buf};
          tx_left    <= `TX_SHIFT_BITS;
          tx_pending <= 1'b0;
        end
      end
    end
  end

  assign start_edge = rx_os && rx_enable && rx_last && !rxd;
  // Multiprocessor filter needs a high stop bit and a set ninth bit
  assign accept_ok  = !rx_complete_flag &&
                      (!multiproc_enable || (rx_vote && rx_shift[8]));

  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_state  <= RX_IDLE;
      rx_phase  <= 4'h0;
      rx_bits   <= 4'h0;
      rx_shift  <= 9'h000;
      rx_last   <= 1'b0;
      rx_accept <= 1'b0;
    end else begin
      rx_accept <= 1'b0;
      if (!rx_enable) begin
        rx_state <= RX_IDLE;
        rx_last  <= 1'b0;
      end else if (rx_os) begin
        rx_phase <= rx_phase + 4'h1;
        case (rx_state)
          RX_IDLE: begin
            rx_last <= rxd;
            if (start_edge) begin
              rx_state <= RX_START;
              rx_phase <= 4'h0;
              rx_bits  <= 4'h0;
            end
          end
          RX_START: begin
            if (rx_phase == `PH_DECIDE) begin
              if (rx_vote) begin
                rx_state <= RX_IDLE;
                rx_last  <= 1'b0;
              end else begin
                rx_state <= RX_DATA;
              end
            end
          end
          RX_DATA: begin
            if (rx_phase == `PH_DECIDE) begin
              rx_shift <= {rx_vote, rx_shift[8:1]};
              rx_bits  <= rx_bits + 4'h1;
              if (rx_bits == `RX_LAST_BIT) begin
                rx_state <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (rx_phase == `PH_DECIDE) begin
              rx_accept <= accept_ok;
              rx_state  <= RX_IDLE;
              rx_last   <= 1'b0;
            end
          end
          default: begin
            rx_state <= RX_IDLE;
          end
        endcase
      end
    end
  end
endmodule // nine_bit_async_serial_port

// [serial_port_defs.vh]
// Register map, field positions and timing constants of the nine-bit serial port
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH

// Register byte offsets
`define OFS_SERIAL_CONTROL  8'h00
`define OFS_SERIAL_DATA     8'h04
`define OFS_POWER_CONTROL   8'h08
`define OFS_RATE_SELECT     8'h0C

// Fields of serial_control_reg
`define CTL_RX_COMPLETE     0
`define CTL_TX_COMPLETE     1
`define CTL_RX_NINTH        2
`define CTL_TX_NINTH        3
`define CTL_RX_ENABLE       4
`define CTL_MULTIPROC       5
`define CTL_MODE3           6

// Fields of power_control_reg and rate select
`define PWR_DOUBLE_RATE     7
`define RATE_TX_TIMER_TWO   0
`define RATE_RX_TIMER_TWO   1

// Oversample prescalers: mode 2 bit = clk/64 or clk/32, 16 samples per bit
`define M2_PRE_SLOW         3'h4
`define M2_PRE_FAST         3'h2
// Timer 1 overflow: bit = ovf/32 or ovf/16
`define T1_PRE_SLOW         3'h2
`define T1_PRE_FAST         3'h1
`define OVERSAMPLE          5'h10

// Receive sample points within a bit (phase counts from the bit boundary), then the receive and transmit bit counts
`define PH_SAMPLE_FIRST     4'h7
`define PH_SAMPLE_LAST      4'h9
`define PH_DECIDE           4'hA
`define RX_LAST_BIT         4'h8
`define TX_SHIFT_BITS       4'hA

// AXI responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// [pulse_divider.v]
// Enable divider: one tick per div step pulses, with synchronous clear
`timescale 1ns/1ps
module pulse_divider #(
  parameter WIDTH = 5
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             clear,
  input  wire             step,
  input  wire [WIDTH-1:0] div,
  output wire             tick
);
  reg [WIDTH-1:0] count;

  // Compare with >= so a divisor lowered mid-count cannot strand the counter
  assign tick = step && (count >= div - {{(WIDTH-1){1'b0}}, 1'b1});

  always @(posedge aclk) begin
    if (!aresetn || clear) begin
      count <= {WIDTH{1'b0}};
    end else if (tick) begin
      count <= {WIDTH{1'b0}};
    end else if (step) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // pulse_divider

// [majority_voter.v]
// Three-sample majority voter for received bits
`timescale 1ns/1ps
module majority_voter (
  input  wire aclk,
  input  wire aresetn,
  input  wire sample,
  input  wire din,
  output wire vote
);
  reg [2:0] samples;

  assign vote = (samples[0] & samples[1]) | (samples[1] & samples[2]) |
                (samples[0] & samples[2]);

  always @(posedge aclk) begin
    if (!aresetn) begin
      samples <= 3'h7;
    end else if (sample) begin
      samples <= {samples[1:0], din};
    end
  end
endmodule // majority_voter

// [serial_port_props.sv]
// Checker for bus handshakes and serial line timing of the serial port
`timescale 1ns/1ps
module serial_port_props (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        txd,
  input wire        serial_irq
);
  reg [7:0] low_run;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Saturating, so a stuck-low line never wraps into a false short bit
  always @(posedge aclk)
    if (!aresetn || txd) low_run <= 8'h00;
    else if (low_run != 8'hFF) low_run <= low_run + 8'h01;

  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> txd && !serial_irq)
    else $error("line or irq active after reset");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bit_width: assert property ($rose(txd) |-> low_run >= 8'h10)
    else $error("low bit shorter than sixteen ticks");
  a_irq_clear: assert property ($fell(serial_irq) |-> $rose(s_axi_bvalid))
    else $error("irq fell without a software write");

  c_tx_frame: cover property ($rose(txd) && low_run >= 8'h10);
  c_irq: cover property ($rose(serial_irq));
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule  // serial_port_props

bind nine_bit_async_serial_port serial_port_props u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .txd(txd),
  .serial_irq(serial_irq)
);

// [remote_serial_node.sv]
// Remote serial node: frames bytes onto rxd and captures frames from txd
`timescale 1ns/1ps
module remote_serial_node (
  input  wire       aclk,
  input  wire [7:0] bitc,
  input  wire       txd,
  output reg        rxd
);
  integer si, gi;

  // Line idles high, driven by the node until a frame starts
  initial rxd = 1'b1;

  task send(input [7:0] d, input n, input s);
    reg [10:0] f;
    begin
      f = {s, n, d, 1'b0};
      for (si = 0; si < 11; si = si + 1) begin
        rxd <= f[si];
        repeat (bitc) @(posedge aclk);
      end
      rxd <= 1'b1;
      @(posedge aclk);
    end
  endtask

  // Low pulse far shorter than a start bit
  task glitch(input [7:0] len);
    begin
      rxd <= 1'b0;
      repeat (len) @(posedge aclk);
      rxd <= 1'b1;
      @(posedge aclk);
    end
  endtask

  // Samples mid-bit at the expected rate, so a wrong rate shows as corrupt bits
  task grab(output [10:0] f);
    begin
      @(negedge txd);
      repeat (bitc / 2) @(posedge aclk);
      for (gi = 0; gi < 11; gi = gi + 1) begin
        f[gi] = txd;
        repeat (bitc) @(posedge aclk);
      end
    end
  endtask
endmodule  // remote_serial_node

// [testbench.sv]
// Self-checking bench for the nine-bit serial port
`timescale 1ns/1ps
`include "serial_port_defs.vh"
module testbench;
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ovf, n;
  reg  [7:0]  awaddr, araddr, bitc, b, last;
  reg  [31:0] wdata, seed, rd_data, want;
  reg  [10:0] frame;
  reg  [1:0]  resp;
  reg  [3:0]  strb;
  wire        awready, wready, bvalid, arready, rvalid, rxd, txd, irq;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     fails, check_count, k;

  nine_bit_async_serial_port u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer1_overflow(ovf), .timer2_overflow(ovf), .rxd(rxd), .txd(txd), .serial_irq(irq)
  );
  remote_serial_node u_node (.aclk(aclk), .bitc(bitc), .txd(txd), .rxd(rxd));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Overflow pulse every other cycle feeds both timer inputs
  always @(posedge aclk) ovf <= aresetn && !ovf;

  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction

  // Clocks per bit, given the overflow pulse period of 2
  function [7:0] bit_len(input m3, input dbl, input t2);
    bit_len = !m3 ? (dbl ? 8'h20 : 8'h40) : 8'h02 * ((t2 || dbl) ? 8'h10 : 8'h20);
  endfunction

  function [31:0] ctl(input m3, input mp, input en, input tx9);
    ctl = (m3 << `CTL_MODE3) | (mp << `CTL_MULTIPROC) | (en << `CTL_RX_ENABLE)
        | (tx9 << `CTL_TX_NINTH);
  endfunction

  task roll;
    begin
      seed = xs(seed);
      b = seed[7:0];
      n = seed[8];
    end
  endtask

  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // Ready may trail valid by a cycle so the slave's response hold is exercised
  task wr(input [7:0] a, input [31:0] d);
    reg done;
    begin
      done = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= seed[1];
      @(posedge aclk);
      while (!done) begin
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid && bready) begin
          resp = bresp;
          done = 1'b1;
        end
        bready <= !done && (bready || bvalid);
        @(posedge aclk);
      end
    end
  endtask

  task rd(input [7:0] a);
    reg got;
    begin
      got = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= seed[0];
      @(posedge aclk);
      while (!got) begin
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid && rready) begin
          rd_data = rdata;
          resp = rresp;
          got = 1'b1;
        end
        rready <= !got && (rready || rvalid);
        @(posedge aclk);
      end
    end
  endtask

  task report_and_stop;
    begin
      $display("Checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  initial begin
    #200000;
    fails = fails + 1;
    report_and_stop;
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    strb = 4'hF;
    bitc = 8'h20;
    seed = 32'h297F;
    fails = 0;
    check_count = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`OFS_SERIAL_CONTROL);
    chk("control reset", 32'h0, rd_data);
    chk("read resp", `RESP_OKAY, resp);
    chk("irq reset", 32'h0, irq);
    rd(8'h10);
    chk("unmapped read", `RESP_SLVERR, resp);
    chk("unmapped data", 32'h0, rd_data);
    wr(8'h10, 32'h0);
    chk("unmapped write", `RESP_SLVERR, resp);
    // A write with byte lane 0 disabled must leave the register alone
    strb <= 4'h0;
    wr(`OFS_SERIAL_CONTROL, 32'h7F);
    strb <= 4'hF;
    chk("masked write resp", `RESP_OKAY, resp);
    rd(`OFS_SERIAL_CONTROL);
    chk("masked write", 32'h0, rd_data);
    $display("Test registers done");
    for (k = 0; k < 5; k = k + 1) begin
      bitc <= bit_len(k > 1, k == 1 || k == 2, k == 4);
      wr(`OFS_POWER_CONTROL, (k == 1 || k == 2) ? 32'h80 : 32'h0);
      wr(`OFS_RATE_SELECT, k == 4 ? 32'h3 : 32'h0);
      roll;
      wr(`OFS_SERIAL_CONTROL, ctl(k > 1, 1'b0, 1'b1, n));
      fork
        u_node.grab(frame);
        wr(`OFS_SERIAL_DATA, {24'h0, b});
      join
      chk("tx frame", {1'b1, n, b, 1'b0}, frame);
      rd(`OFS_SERIAL_CONTROL);
      chk("tx flag", 32'h1, rd_data[`CTL_TX_COMPLETE]);
      chk("tx irq", 32'h1, irq);
      roll;
      last = b;
      wr(`OFS_SERIAL_CONTROL, ctl(k > 1, 1'b0, 1'b1, 1'b0));
      u_node.send(b, n, seed[9]);
      want = ctl(k > 1, 1'b0, 1'b1, 1'b0) | (n << `CTL_RX_NINTH) | (32'h1 << `CTL_RX_COMPLETE);
      rd(`OFS_SERIAL_CONTROL);
      chk("rx control", want, rd_data);
      roll;
      u_node.send(b, ~n, 1'b1);
      rd(`OFS_SERIAL_CONTROL);
      chk("rx held flags", want, rd_data);
      rd(`OFS_SERIAL_DATA);
      chk("rx held byte", last, rd_data);
      $display("Test rate %0d done", k);
    end
    for (k = 0; k < 3; k = k + 1) begin
      wr(`OFS_SERIAL_CONTROL, ctl(1'b1, 1'b1, 1'b1, 1'b0));
      roll;
      u_node.send(b, k != 0, k != 1);
      rd(`OFS_SERIAL_CONTROL);
      chk("address accept", k == 2, rd_data[`CTL_RX_COMPLETE]);
      chk("address irq", k == 2, irq);
    end
    rd(`OFS_SERIAL_DATA);
    chk("address byte", b, rd_data);
    $display("Test multiprocessor done");
    wr(`OFS_SERIAL_CONTROL, ctl(1'b1, 1'b0, 1'b1, 1'b0));
    u_node.glitch(8'h04);
    repeat (64) @(posedge aclk);
    rd(`OFS_SERIAL_CONTROL);
    chk("glitch ignored", 32'h0, rd_data[`CTL_RX_COMPLETE]);
    roll;
    u_node.send(b, n, 1'b1);
    rd(`OFS_SERIAL_DATA);
    chk("after glitch", b, rd_data);
    wr(`OFS_SERIAL_CONTROL, ctl(1'b1, 1'b0, 1'b0, 1'b0));
    u_node.send(~b, n, 1'b1);
    rd(`OFS_SERIAL_CONTROL);
    chk("receiver off", 32'h0, rd_data[`CTL_RX_COMPLETE]);
    $display("Test start detect done");
    report_and_stop;
  end
endmodule  // testbench
